// file: dac_serial_write_port_tb_top.sv
/* bench for the serial write port.
 assumes the dswp_host model drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_tb_top;
   logic        mclk_i;
   logic        rst_i;
   wire logic   sclk, sync_n, din;
   logic [11:0] code;
   logic [1:0]  mode;
   logic        upd;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          n_upd = 0;
   // 100 MHz clock
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   dswp_host i_host (.mclk_i(mclk_i), .sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
   dswp_port i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .sync_n_i(sync_n),
      .din_i(din), .code_o(code), .power_mode_o(mode), .update_o(upd));
   // count update pulses
   always @(negedge mclk_i)
      if (upd === 1'b1) n_upd++;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // one frame, then outputs and pulse count
   task automatic frame(input logic [15:0] w, input int n, input logic [13:0] e, input int p);
      int u;
      u = n_upd;
      @(posedge mclk_i);
      i_host.send(w, n);
      repeat (4) @(posedge mclk_i);
      chk({2'h0, mode, code}, {2'h0, e});
      chk(16'(n_upd - u), 16'(p));
   endtask : frame
   task automatic t_reset();
      chk({2'h0, mode, code}, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_modes();
      for (int m = 0; m < 4; m++)
         frame({m[1:0], 12'ha5c ^ 12'(m), 2'h3}, 16, {m[1:0], 12'ha5c ^ 12'(m)}, 1);
      $display("test modes done");
   endtask : t_modes
   task automatic t_abort();
      frame(16'h0fff, 10, 14'h3a5f, 0);
      frame(16'h448c, 16, 14'h1123, 1);
      $display("test abort done");
   endtask : t_abort
   task automatic t_extra();
      frame(16'h8004, 17, 14'h2001, 1);
      $display("test extra done");
   endtask : t_extra
   task automatic t_idle();
      int u;
      u = n_upd;
      i_host.idle_clk(16);
      repeat (4) @(posedge mclk_i);
      chk({2'h0, mode, code}, 16'h2001);
      chk(16'(n_upd - u), 16'h0000);
      $display("test idle done");
   endtask : t_idle
   task automatic t_rst_mid();
      rst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk({2'h0, mode, code}, 16'h0000);
      repeat (3) @(posedge mclk_i);
      frame(16'hc008, 16, 14'h3002, 1);
      $display("test mid reset done");
   endtask : t_rst_mid
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // main sequence
   initial
   begin
      rst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      t_reset();
      t_modes();
      t_abort();
      t_extra();
      t_idle();
      t_rst_mid();
      final_report();
   end
   // watchdog, run needs about 24 us
   initial
   begin
      #100000;
      n_mismatch++;
      final_report();
   end
endmodule : dac_serial_write_port_tb_top
`default_nettype wire

// file: dswp_consts.svh
/*
 constants for the serial write port: frame length, word field positions,
 power mode encodings and reset values.
 assumes nothing beyond being included by bare name.
*/
`ifndef DSWP_CONSTS_SVH
`define DSWP_CONSTS_SVH

`define DSWP_WORD_BITS      16
`define DSWP_CNT_LAST       5'h10
`define DSWP_MODE_HI_POS    15
`define DSWP_MODE_LO_POS    14
`define DSWP_CODE_MSB_POS   13
`define DSWP_CODE_LSB_POS   2
`define DSWP_CODE_RST       12'h000
`define DSWP_MODE_RST       2'h0
`define DSWP_MODE_NORMAL    2'h0
`define DSWP_MODE_PD_1K     2'h1
`define DSWP_MODE_PD_100K   2'h2
`define DSWP_MODE_HIZ       2'h3

`endif

// file: dswp_host.sv
/* host model framing words onto the serial pins.
 assumes its clock is the 100 MHz bench clock. */
`timescale 1ns/1ps
`default_nettype none
module dswp_host
(
   // clock
   input  wire logic mclk_i,
   // serial pins
   output var logic  sclk_o,
   output var logic  sync_n_o,
   output var logic  din_o
);
   // idle: clock high, select high
   initial {sclk_o, sync_n_o, din_o} = 3'h6;
   // n bits msb first, 160 ns clock
   task automatic send(input logic [15:0] w, input int n);
      sync_n_o <= 1'b0;
      for (int i = 15; i > 15 - n; i--)
      begin
         din_o <= w[i[3:0]];
         repeat (8) @(posedge mclk_i);
         sclk_o <= 1'b0;
         repeat (8) @(posedge mclk_i);
         sclk_o <= 1'b1;
      end
      repeat (8) @(posedge mclk_i);
      sync_n_o <= 1'b1;
      din_o <= ~din_o; // released line flips
      repeat (8) @(posedge mclk_i);
   endtask : send
   // n clock pulses with select high, to be refused
   task automatic idle_clk(input int n);
      repeat (n)
      begin
         repeat (8) @(posedge mclk_i);
         sclk_o <= 1'b0;
         repeat (8) @(posedge mclk_i);
         sclk_o <= 1'b1;
      end
   endtask : idle_clk
endmodule : dswp_host
`default_nettype wire

// file: dswp_pkg.sv
/*
 types shared by the serial write port.
 assumes dswp_consts.svh is on the include path.
*/
`include "dswp_consts.svh"

package dswp_pkg;

   // output stage selected by the two power mode bits
   typedef enum logic [1:0]
   {
      DSWP_NORMAL,
      DSWP_PD_1K,
      DSWP_PD_100K,
      DSWP_HIZ
   } dswp_mode_type;

   // whole state of the port
   typedef struct packed
   {
      logic [2:0]  sclk_sync;  // sclk synchroniser plus edge history
      logic [2:0]  sel_sync;   // frame select synchroniser plus history
      logic [1:0]  din_sync;   // data synchroniser
      logic [15:0] shift;      // input shift register
      logic [4:0]  cnt;        // falling edges seen in this frame
      logic        done;       // word executed, later edges ignored
      logic [11:0] code;       // converter register
      logic [1:0]  mode;       // power mode
      logic        upd;        // one-cycle update pulse
   } dswp_state_type;

endpackage : dswp_pkg

// file: dswp_port.sv
/*
 serial write port of a single-channel converter, sampled on mclk_i.
 assumes mclk_i is much faster than the serial clock (at least 4x) and
 that the host keeps data steady around each falling serial clock edge.
 the converter's analog stage reads code_o and power_mode_o directly.
*/
`timescale 1ns/1ps
`default_nettype none

// offsets, field positions and reset values live in the shared header
`include "dswp_consts.svh"

// Notes on behaviour
// - shift only while frame select held low
// - sample data on each serial clock fall
// - execute word on sixteenth falling edge
// - early select rise aborts, clears shift register
// - mode bits 15..14, code follows msb first
// - decode mode bits into four output modes
// - reset gives zero code, normal mode
module dswp_port
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // serial pins
   input  wire logic        sclk_i,
   input  wire logic        sync_n_i,
   input  wire logic        din_i,
   // converter side
   output logic [11:0]      code_o,
   output logic [1:0]       power_mode_o,
   output logic             update_o
);

   dswp_pkg::dswp_state_type s_q;  // registered state
   dswp_pkg::dswp_state_type s_d;  // next state

   logic                     sclk_fall;  // falling serial clock seen after sync
   logic                     sel_fall;   // start of a frame
   logic                     sel_low;    // frame select active
   logic                     shift_ok;   // this cycle takes one data bit
   dswp_pkg::dswp_mode_type  mode_dec;   // output stage named by the mode bits

   // edges judged on stages 1 and 2 only, never on stage 0;
   // stage 0 may still be metastable, so only stage 1 reads it
   assign sclk_fall = s_q.sclk_sync[2] & ~s_q.sclk_sync[1];
   assign sel_fall  = s_q.sel_sync[2] & ~s_q.sel_sync[1];
   assign sel_low   = ~s_q.sel_sync[1];

   // a frame start re-arms the port at once, so a serial clock fall in
   // the very cycle of the select fall is not lost to a stale done flag
   assign shift_ok  = sel_low & (sel_fall | ~s_q.done) & sclk_fall;

   // decode of the two mode bits as they stand just before the last shift;
   // word bits 15 and 14 sit one place lower in the register at that point
   always_comb
   begin
      mode_dec = dswp_pkg::DSWP_NORMAL;
      case ({s_q.shift[`DSWP_MODE_HI_POS-1], s_q.shift[`DSWP_MODE_LO_POS-1]})
         `DSWP_MODE_NORMAL  : mode_dec = dswp_pkg::DSWP_NORMAL;   // output buffer on
         `DSWP_MODE_PD_1K   : mode_dec = dswp_pkg::DSWP_PD_1K;    // 1k to ground
         `DSWP_MODE_PD_100K : mode_dec = dswp_pkg::DSWP_PD_100K;  // 100k to ground
         `DSWP_MODE_HIZ     : mode_dec = dswp_pkg::DSWP_HIZ;      // output floats
         default            : mode_dec = dswp_pkg::DSWP_NORMAL;   // unreachable, safe fallback
      endcase
   end

   // next-state logic
   always_comb
   begin
      s_d           = s_q;
      s_d.upd       = 1'b0;  // strobe lasts one cycle only
      // every pin walks through two flops before any logic reads it
      s_d.sclk_sync = {s_q.sclk_sync[1:0], sclk_i};
      s_d.sel_sync  = {s_q.sel_sync[1:0], sync_n_i};
      s_d.din_sync  = {s_q.din_sync[0], din_i};
      // frame bookkeeping follows the synchronised select level
      if (sel_fall)
      begin
         // new frame; host keeps select high between frames
         s_d.cnt   = 5'h00;
         s_d.done  = 1'b0;
         s_d.shift = 16'h0000;
      end
      else if (!sel_low)
      begin
         // high select: any unfinished frame is dropped
         s_d.cnt   = 5'h00;
         s_d.shift = 16'h0000;
      end
      // one bit per synchronised serial clock fall inside an armed frame
      if (shift_ok)
      begin
         // aligned with the synchronised data, so same delay
         s_d.shift = {s_q.shift[14:0], s_q.din_sync[1]};
         s_d.cnt   = s_q.cnt + 5'h01;
         // sixteenth bit: execute now; the last bit is a don't care, so
         // the fields are taken from the register before it shifts
         if (s_q.cnt + 5'h01 == `DSWP_CNT_LAST)
         begin
            s_d.done = 1'b1;  // later edges ignored until select falls again
            s_d.upd  = 1'b1;  // one-cycle strobe to the converter
            // mode bits first, then code msb first
            s_d.mode = mode_dec;
            s_d.code = s_q.shift[`DSWP_CODE_MSB_POS-1:`DSWP_CODE_LSB_POS-1];
         end
      end
   end

   // state register; reset zeroes code and picks normal mode.
   // the asynchronous reset only loads constants, never a pin value
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q           <= '0;
         // synchronisers start at the idle pin levels, so no false
         // edge is seen in the first cycles after release
         s_q.sclk_sync <= 3'h7;  // idle serial clock is high
         s_q.sel_sync  <= 3'h7;  // idle select is high
         s_q.code      <= `DSWP_CODE_RST;
         s_q.mode      <= `DSWP_MODE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs taken straight from the state flops, no logic after them
   assign code_o       = s_q.code;
   assign power_mode_o = s_q.mode;
   assign update_o     = s_q.upd;

   // checks below watch state and outputs on the system clock; the serial
   // pins are only seen through the synchronisers, so every step shows up
   // a few system clocks after the pin moved

   // the sixteenth accepted serial clock fall of a frame
   sequence s_last_edge;
      shift_ok && s_q.cnt == 5'h0f;
   endsequence

   // select high while a frame is still short of sixteen bits
   sequence s_cut_frame;
      !sel_low && s_q.cnt != 5'h00 && !s_q.done;
   endsequence

   // sixteen edges into a frame must give one update
   a_upd_on_last : assert property (@(posedge mclk_i) disable iff (rst_i)
      s_last_edge |=> update_o)
      else $error("no update on sixteenth edge");

   // the last edge closes the frame with the counter at sixteen
   a_done_after : assert property (@(posedge mclk_i) disable iff (rst_i)
      s_last_edge |=> s_q.done && s_q.cnt == `DSWP_CNT_LAST)
      else $error("frame not closed after last edge");

   // a cut frame neither updates nor touches the converter
   a_cut_no_upd : assert property (@(posedge mclk_i) disable iff (rst_i)
      s_cut_frame |=> !update_o && $stable(code_o) && $stable(power_mode_o))
      else $error("cut frame changed converter");

   // a new frame starts from an empty counter
   a_frame_rearm : assert property (@(posedge mclk_i) disable iff (rst_i)
      sel_fall |=> !s_q.done && s_q.cnt <= 5'h01)
      else $error("frame start did not re-arm");

   // edges after the sixteenth leave the frame untouched
   a_extra_ignored : assert property (@(posedge mclk_i) disable iff (rst_i)
      (sel_low && !sel_fall && s_q.done && sclk_fall) |=> $stable(s_q.cnt) && $stable(s_q.shift))
      else $error("edge after sixteenth accepted");

   // reset holds zero code and normal mode on the outputs
   a_reset_zero : assert property (@(posedge mclk_i)
      rst_i |-> code_o == `DSWP_CODE_RST && power_mode_o == `DSWP_MODE_RST && !update_o)
      else $error("reset state not zero");

   // outputs stay still unless an update fires
   a_hold_no_upd : assert property (@(posedge mclk_i) disable iff (rst_i)
      !s_d.upd |=> $stable(code_o) && $stable(power_mode_o))
      else $error("converter changed without update");

   // high select empties the counter
   a_abort_clear : assert property (@(posedge mclk_i) disable iff (rst_i)
      (!sel_low && !sel_fall) |=> s_q.cnt == 5'h00 && s_q.shift == 16'h0000)
      else $error("abort did not clear");

   // no update from a serial clock fall while select is high
   a_no_shift_hi : assert property (@(posedge mclk_i) disable iff (rst_i)
      (!sel_low && sclk_fall) |=> !update_o)
      else $error("shift while deselected");

   // counter never passes sixteen
   a_cnt_bound : assert property (@(posedge mclk_i) disable iff (rst_i)
      s_q.cnt <= `DSWP_CNT_LAST)
      else $error("counter overflow");

   // update loads captured mode bits
   a_mode_load : assert property (@(posedge mclk_i) disable iff (rst_i)
      s_d.upd |=> power_mode_o == $past(s_q.shift[14:13]))
      else $error("mode bits misplaced");

   // update loads captured code bits
   a_code_load : assert property (@(posedge mclk_i) disable iff (rst_i)
      s_d.upd |=> code_o == $past(s_q.shift[12:1]))
      else $error("code bits misplaced");

   // an update pulse is never followed by another in the next cycle
   a_done_quiet : assert property (@(posedge mclk_i) disable iff (rst_i)
      update_o |=> !update_o)
      else $error("double update");

endmodule : dswp_port

`default_nettype wire
